// ==== logic/fnd_pkg.sv ====
package fnd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets on the control register port.
	localparam logic [7:0] IN_DIV_ADDR   = 8'h0A;
	localparam logic [7:0] FB_DIV_ADDR   = 8'h0B;
	localparam logic [7:0] FRAC_CFG_ADDR = 8'h0C;
	localparam logic [7:0] OUT_DIV_ADDR  = 8'h0D;

	////////////////////////////////////////////////////////////////////////////////
	// Field widths and positions.
	localparam int IN_DIV_W    = 7;
	localparam int FB_DIV_W    = 8;
	localparam int OUT_DIV_W   = 4;
	localparam int FRAC_W      = 5;
	localparam int FRAC_LSB    = 0;
	localparam int DITHER_LSB  = 5;
	localparam int DITHER_W    = 2;
	localparam int HI_VCO_BIT  = 7;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values: every divider starts switched off, no fraction, medium dither.
	localparam logic [6:0] IN_DIV_RST   = 7'h00;
	localparam logic [7:0] FB_DIV_RST   = 8'h00;
	localparam logic [7:0] FRAC_CFG_RST = 8'h00;
	localparam logic [3:0] OUT_DIV_RST  = 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Dither selection codes and amounts.
	typedef enum logic [1:0] {
		FND_DITHER_MEDIUM   = 2'b00,
		FND_DITHER_SMALL    = 2'b01,
		FND_DITHER_LARGE    = 2'b10,
		FND_DITHER_RESERVED = 2'b11
	} fnd_dither_t;

	localparam logic [5:0] DITHER_MEDIUM_AMT = 6'h20;
	localparam logic [5:0] DITHER_SMALL_AMT  = 6'h10;
	localparam logic [5:0] DITHER_LARGE_AMT  = 6'h30;

	////////////////////////////////////////////////////////////////////////////////
	// Modulator accumulator: the five-bit fraction is a numerator over 32,
	// refined by ACC_EXTRA bits so that dither stays below one fraction step.
	localparam int          FRAC_MODULUS = 32;
	localparam int          ACC_EXTRA    = 7;
	localparam int          ACC_W        = FRAC_W + ACC_EXTRA;
	localparam int          SUM_W        = ACC_W + 2;
	localparam logic [15:0] LFSR_SEED    = 16'hACE1;

	////////////////////////////////////////////////////////////////////////////////
	// Oscillator ranges in MHz, reported to the analog band control.
	localparam int VCO_STD_MIN_MHZ  = 40;
	localparam int VCO_STD_MAX_MHZ  = 55;
	localparam int VCO_HIGH_MIN_MHZ = 60;
	localparam int VCO_HIGH_MAX_MHZ = 80;

endpackage

// ==== logic/fnd_half_div.sv ====
`timescale 1ns/1ps

// Half-integer divider: one tick per (code + 1) edges of the input level, so the tick rate
// is the input frequency divided by (code + 1) / 2. Code zero stops the divider.
module fnd_half_div #(
	parameter int W = 7
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         level_in,
	input  wire logic [W-1:0] code,
	output logic              tick
);

	typedef struct packed {
		logic         prev;
		logic [W-1:0] cnt;
		logic         tick;
	} fnd_div_state_t;

	fnd_div_state_t st_reg;
	fnd_div_state_t st_next;

	////////////////////////////////////////////////////////////////////////////////
	// Count both edges of the input; each edge is half an input period.
	always_comb begin
		st_next      = st_reg;
		st_next.prev = level_in;
		st_next.tick = 1'b0;
		if (code == '0) begin
			st_next.cnt = '0;
		end else if (level_in != st_reg.prev) begin
			if (st_reg.cnt >= code) begin
				st_next.cnt  = '0;
				st_next.tick = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt + W'(1);
			end
		end
	end

	// State register.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;

endmodule

// ==== logic/fnd_pll_divider.sv ====
`timescale 1ns/1ps

// Operation
// - Fraction code k adds k/32 to the feedback division.
// - Dither field selects medium 32, small 16 or large 48.
// - High range bit clear keeps 40 to 55 MHz; set raises both limits.
// - Total feedback division is integer code plus fraction code over 32.
// - Fraction code zero gives a plain integer feedback divider.
// - Output frequency is reference times feedback over input times output division.
// - Audio clocks up to 25 MHz, error noise-shaped out of band.
// - Five-bit fraction gives exact 48 and 44.1 kHz clocks at 125 times.
// - Output divider supports half-integer ratios such as 4.5.
// - Bypass path runs 8 to 48 kHz directly from a 12 MHz clock.
// - Input division is input code plus one, halved; zero switches it off.
// - Feedback integer part is the eight-bit code; zero switches it off.
// - Output division is four-bit code plus one, halved; zero switches it off.
module fnd_pll_divider (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       mclk_pin,
	input  wire logic       bclk_pin,
	input  wire logic       vco_pin,
	input  wire logic       ref_sel,
	input  wire logic       pll_bypass,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            comp_tick,
	output logic            fb_tick,
	output logic            audio_tick,
	output logic            vco_range_high,
	output logic      [5:0] dither_level,
	output logic            modulator_active
);

	typedef struct packed {
		logic [1:0]                       mclk_s;
		logic [1:0]                       bclk_s;
		logic [1:0]                       vco_s;
		logic                             vco_prev;
		logic                             ref_prev;
		logic [fnd_pkg::IN_DIV_W-1:0]     in_div_code;
		logic [fnd_pkg::FB_DIV_W-1:0]     fb_div_code;
		logic [7:0]                       frac_cfg;
		logic [fnd_pkg::OUT_DIV_W-1:0]    out_div_code;
		logic [fnd_pkg::FRAC_W-1:0]       frac_act;
		logic [5:0]                       dither_act;
		logic                             hi_vco;
		logic [fnd_pkg::FB_DIV_W:0]       fb_cnt;
		logic                             fb_extra;
		logic [fnd_pkg::ACC_W-1:0]        acc;
		logic [5:0]                       dith_prev;
		logic [15:0]                      lfsr;
		logic                             fb_tick;
		logic                             audio_tick;
		logic [7:0]                       rdata;
	} fnd_state_t;

	fnd_state_t st_reg;
	fnd_state_t st_next;
	logic [1:0] rst_sync_reg;
	logic       rst_n;
	logic       ref_level;
	logic       out_div_tick;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_n     = rst_sync_reg[1];
	assign ref_level = ref_sel ? st_reg.bclk_s[1] : st_reg.mclk_s[1];

	////////////////////////////////////////////////////////////////////////////////
	// Input and output dividers, both half-integer.
	fnd_half_div #(
		.W (fnd_pkg::IN_DIV_W)
	) u_in_div (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.level_in (ref_level),
		.code     (st_reg.in_div_code),
		.tick     (comp_tick)
	);

	fnd_half_div #(
		.W (fnd_pkg::OUT_DIV_W)
	) u_out_div (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.level_in (st_reg.vco_s[1]),
		.code     (st_reg.out_div_code),
		.tick     (out_div_tick)
	);

	// Dither amount decode; the reserved code falls back to medium.
	function automatic logic [5:0] dither_amt(input logic [1:0] sel);
		case (fnd_pkg::fnd_dither_t'(sel))
			fnd_pkg::FND_DITHER_SMALL: dither_amt = fnd_pkg::DITHER_SMALL_AMT;
			fnd_pkg::FND_DITHER_LARGE: dither_amt = fnd_pkg::DITHER_LARGE_AMT;
			fnd_pkg::FND_DITHER_MEDIUM: dither_amt = fnd_pkg::DITHER_MEDIUM_AMT;
			default: dither_amt = fnd_pkg::DITHER_MEDIUM_AMT;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic: synchronisers, register port, feedback divider and modulator.
	always_comb begin
		logic                        vco_rise;
		logic                        ref_rise;
		logic [fnd_pkg::FB_DIV_W:0]  fb_len;
		logic [5:0]                  dith_now;
		logic [fnd_pkg::SUM_W-1:0]   sum;
		vco_rise = 1'b0;
		ref_rise = 1'b0;
		fb_len   = '0;
		dith_now = '0;
		sum      = '0;
		st_next  = st_reg;

		// Pins pass two flops; edge detection reads only the second stage.
		st_next.mclk_s   = {st_reg.mclk_s[0], mclk_pin};
		st_next.bclk_s   = {st_reg.bclk_s[0], bclk_pin};
		st_next.vco_s    = {st_reg.vco_s[0], vco_pin};
		st_next.vco_prev = st_reg.vco_s[1];
		st_next.ref_prev = ref_level;
		vco_rise = st_reg.vco_s[1] & ~st_reg.vco_prev;
		ref_rise = ref_level & ~st_reg.ref_prev;

		// Register writes; unmapped addresses are ignored.
		if (reg_wr) begin
			case (reg_addr)
				fnd_pkg::IN_DIV_ADDR: st_next.in_div_code = reg_wdata[fnd_pkg::IN_DIV_W-1:0];
				fnd_pkg::FB_DIV_ADDR: st_next.fb_div_code = reg_wdata;
				fnd_pkg::FRAC_CFG_ADDR: st_next.frac_cfg = reg_wdata;
				fnd_pkg::OUT_DIV_ADDR: st_next.out_div_code = reg_wdata[fnd_pkg::OUT_DIV_W-1:0];
				default: st_next.frac_cfg = st_reg.frac_cfg;
			endcase
		end

		// Reads return stored fields only; unmapped addresses read zero.
		if (reg_rd) begin
			case (reg_addr)
				fnd_pkg::IN_DIV_ADDR: st_next.rdata = {1'b0, st_reg.in_div_code};
				fnd_pkg::FB_DIV_ADDR: st_next.rdata = st_reg.fb_div_code;
				fnd_pkg::FRAC_CFG_ADDR: st_next.rdata = st_reg.frac_cfg;
				fnd_pkg::OUT_DIV_ADDR: st_next.rdata = {4'h0, st_reg.out_div_code};
				default: st_next.rdata = 8'h00;
			endcase
		end

		// Oscillator band follows the range bit straight away.
		st_next.hi_vco = st_reg.frac_cfg[fnd_pkg::HI_VCO_BIT];

		// Feedback divider: N or N + 1 oscillator cycles per feedback tick.
		fb_len          = {1'b0, st_reg.fb_div_code} + {{fnd_pkg::FB_DIV_W{1'b0}}, st_reg.fb_extra};
		st_next.fb_tick = 1'b0;
		if (st_reg.fb_div_code == '0) begin
			st_next.fb_cnt   = '0;
			st_next.fb_extra = 1'b0;
			st_next.acc      = '0;
		end else if (vco_rise) begin
			if (st_reg.fb_cnt + 9'h001 >= fb_len) begin
				st_next.fb_cnt  = '0;
				st_next.fb_tick = 1'b1;
				// Modulator update: shadowed fields load here, never mid-cycle.
				st_next.frac_act   = st_reg.frac_cfg[fnd_pkg::FRAC_LSB +: fnd_pkg::FRAC_W];
				st_next.dither_act = dither_amt(st_reg.frac_cfg[fnd_pkg::DITHER_LSB +:
					fnd_pkg::DITHER_W]);
				st_next.lfsr = {st_reg.lfsr[14:0],
					st_reg.lfsr[15] ^ st_reg.lfsr[13] ^ st_reg.lfsr[12] ^ st_reg.lfsr[10]};
				if (st_next.frac_act == '0) begin
					st_next.fb_extra  = 1'b0;
					st_next.acc       = '0;
					st_next.dith_prev = '0;
				end else begin
					// First-difference dither is zero-mean, so the average stays k/32.
					dith_now = st_reg.lfsr[0] ? st_next.dither_act : 6'h00;
					sum = {2'b00, st_reg.acc}
						+ {2'b00, st_next.frac_act, {fnd_pkg::ACC_EXTRA{1'b0}}}
						+ {8'h00, dith_now} - {8'h00, st_reg.dith_prev};
					st_next.fb_extra  = sum[fnd_pkg::ACC_W];
					st_next.acc       = sum[fnd_pkg::ACC_W-1:0];
					st_next.dith_prev = dith_now;
				end
			end else begin
				st_next.fb_cnt = st_reg.fb_cnt + 9'h001;
			end
		end

		// Audio clock: divider output, or the reference itself in bypass.
		st_next.audio_tick = pll_bypass ? ref_rise : out_div_tick;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg              <= '0;
			st_reg.in_div_code  <= fnd_pkg::IN_DIV_RST;
			st_reg.fb_div_code  <= fnd_pkg::FB_DIV_RST;
			st_reg.frac_cfg     <= fnd_pkg::FRAC_CFG_RST;
			st_reg.out_div_code <= fnd_pkg::OUT_DIV_RST;
			st_reg.dither_act   <= fnd_pkg::DITHER_MEDIUM_AMT;
			st_reg.lfsr         <= fnd_pkg::LFSR_SEED;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flops, except modulator_active, which is decoded from the stored fraction.
	assign reg_rdata        = st_reg.rdata;
	assign fb_tick          = st_reg.fb_tick;
	assign audio_tick       = st_reg.audio_tick;
	assign vco_range_high   = st_reg.hi_vco;
	assign dither_level     = st_reg.dither_act;
	assign modulator_active = (st_reg.frac_act != '0);

endmodule

// ==== testbench/fnd_ref_src.sv ====
`timescale 1ns/1ps
// Far-side clocks; each edge sits 3 ns after a ref_clk edge, so sampling never races.
module fnd_ref_src #(
	parameter int MH = 30,
	parameter int BH = 50,
	parameter int VH = 40
) (
	output logic mclk_pin,
	output logic bclk_pin,
	output logic vco_pin
);
	// Free-running master, sample-synchronous bit and oscillator clocks.
	initial begin
		mclk_pin = 1'b0;
		bclk_pin = 1'b0;
		vco_pin  = 1'b0;
		#3;
		fork
			forever #MH mclk_pin = ~mclk_pin;
			forever #BH bclk_pin = ~bclk_pin;
			forever #VH vco_pin = ~vco_pin;
		join
	end
endmodule

// ==== testbench/fnd_pll_divider_props.sv ====
`timescale 1ns/1ps
// Port-level checks; shadows hold what software last wrote.
module fnd_pll_divider_props (
	input wire logic       ref_clk,
	input wire logic       resetn,
	input wire logic       mclk_pin,
	input wire logic       bclk_pin,
	input wire logic       vco_pin,
	input wire logic       ref_sel,
	input wire logic       pll_bypass,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       comp_tick,
	input wire logic       fb_tick,
	input wire logic       audio_tick,
	input wire logic       vco_range_high,
	input wire logic [5:0] dither_level,
	input wire logic       modulator_active
);
	logic [7:0] frac_reg;
	logic [6:0] in_reg;
	logic [2:0] off_reg;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////
	// Shadows, and a saturating count of cycles with the input divider off.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			frac_reg <= 8'h00;
			in_reg   <= 7'h00;
			off_reg  <= 3'h0;
		end else begin
			if (reg_wr && reg_addr == fnd_pkg::FRAC_CFG_ADDR)
				frac_reg <= reg_wdata;
			if (reg_wr && reg_addr == fnd_pkg::IN_DIV_ADDR)
				in_reg <= reg_wdata[6:0];
			if (in_reg != 7'h00)
				off_reg <= 3'h0;
			else if (off_reg != 3'h7)
				off_reg <= off_reg + 3'h1;
		end
	end
	////////////////////////////////
	dither_legal_a : assert property (
		dither_level inside {6'h20, 6'h10, 6'h30}) else $error("illegal dither amount");
	range_follow_a : assert property (
		reg_wr && reg_addr == fnd_pkg::FRAC_CFG_ADDR |-> ##2 vco_range_high == $past(reg_wdata[7], 2))
		else $error("range bit not applied");
	frac_readback_a : assert property (
		reg_rd && reg_addr == fnd_pkg::FRAC_CFG_ADDR |=> reg_rdata == $past(frac_reg))
		else $error("fraction read back wrong");
	unmapped_zero_a : assert property (
		reg_rd && !(reg_addr inside {[8'h0A:8'h0D]}) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	input_off_a : assert property (
		off_reg == 3'h7 |-> !comp_tick) else $error("tick from stopped input divider");
	dither_update_a : assert property (
		!$stable(dither_level) |-> fb_tick || $past(fb_tick)) else $error("dither moved off update");
	active_update_a : assert property (
		!$stable(modulator_active) |-> fb_tick || $past(fb_tick)) else $error("fraction moved off update");
	audio_pulse_a : assert property (
		audio_tick |=> !audio_tick) else $error("output tick longer than one cycle");
endmodule

bind fnd_pll_divider fnd_pll_divider_props props (
	.ref_clk, .resetn, .mclk_pin, .bclk_pin, .vco_pin, .ref_sel, .pll_bypass,
	.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .comp_tick, .fb_tick,
	.audio_tick, .vco_range_high, .dither_level, .modulator_active
);

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for the divider block.
module tb;
	logic        ref_clk, resetn, mclk_pin, bclk_pin, vco_pin, ref_sel, pll_bypass;
	logic        reg_wr, reg_rd, comp_tick, fb_tick, audio_tick, vco_range_high;
	logic        modulator_active;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
	logic [5:0]  dither_level;
	int          p, n_fail, n_checks;
	// Rows of address, write data, expected read-back.
	logic [23:0] rows [6] = '{24'h0AFF7F, 24'h0BA5A5, 24'h0DFF0F, 24'h095500, 24'h0E3300, 24'h0C8585};
	logic [7:0]  cin [3]  = '{8'h01, 8'h02, 8'h09};
	logic [7:0]  cout [3] = '{8'h01, 8'h08, 8'h0F};
	logic [5:0]  amts [4] = '{6'h20, 6'h10, 6'h30, 6'h20};
	////////////////////////////////
	// Clock, design and far side.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	fnd_pll_divider dut (.ref_clk, .resetn, .mclk_pin, .bclk_pin, .vco_pin, .ref_sel, .pll_bypass,
		.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .comp_tick, .fb_tick, .audio_tick,
		.vco_range_high, .dither_level, .modulator_active);
	fnd_ref_src src (.mclk_pin, .bclk_pin, .vco_pin);
	////////////////////////////////
	// Register access, comparison and tick measurement.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		#1 v = reg_rdata;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %0d seen %0d", nm, e, s);
		end
	endtask
	function automatic logic tk(input int w);
		return w == 0 ? comp_tick : (w == 1 ? fb_tick : audio_tick);
	endfunction
	// Skips two ticks to settle, then counts cycles over k tick periods.
	task automatic span(input int w, input int k, output int c);
		int n;
		n = 0;
		c = 0;
		repeat (2) do begin @(posedge ref_clk); #1; n++; end while (tk(w) !== 1'b1 && n < 3000);
		repeat (k) do begin @(posedge ref_clk); #1; c++; end while (tk(w) !== 1'b1 && c < 3000);
	endtask
	task automatic results;
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog against a hang.
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		results();
	end
	////////////////////////////////
	// Main sequence.
	initial begin
		{n_fail, n_checks} = 64'h0;
		{resetn, ref_sel, pll_bypass, reg_wr, reg_rd} = 5'h00;
		{reg_addr, reg_wdata} = 16'h0000;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			rd(8'h0A + 8'(i), d);
			chk("reset value", 0, d);
		end
		chk("reset dither", 6'h20, dither_level);
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], d);
			chk("read back", rows[i][7:0], d);
		end
		chk("range bit", 1, vco_range_high);
		// Input divider periods from both reference clocks, then output divider periods for each code.
		foreach (cin[i]) begin
			wr(fnd_pkg::IN_DIV_ADDR, cin[i]);
			span(0, 1, p);
			chk("input period", (cin[i] + 1) * 3, p);
		end
		wr(fnd_pkg::IN_DIV_ADDR, 8'h01);
		ref_sel <= 1'b1;
		span(0, 1, p);
		chk("bit clock period", 10, p);
		@(posedge ref_clk);
		ref_sel <= 1'b0;
		foreach (cout[i]) begin
			wr(fnd_pkg::OUT_DIV_ADDR, cout[i]);
			span(2, 1, p);
			chk("output period", (cout[i] + 1) * 4, p);
		end
		// Switch the audio source one cycle clear of a tick, so two ticks never abut.
		@(posedge ref_clk);
		pll_bypass <= 1'b1;
		span(2, 1, p);
		chk("bypass period", 6, p);
		@(posedge ref_clk);
		pll_bypass <= 1'b0;
		wr(fnd_pkg::FB_DIV_ADDR, 8'h03);
		wr(fnd_pkg::FRAC_CFG_ADDR, 8'h00);
		span(1, 4, p);
		chk("integer feedback span", 96, p);
		chk("modulator idle", 0, modulator_active);
		wr(fnd_pkg::FB_DIV_ADDR, 8'h02);
		wr(fnd_pkg::FRAC_CFG_ADDR, 8'h10);
		span(1, 32, p);
		chk("fraction span", 1, p >= 632 && p <= 648);
		chk("modulator running", 1, modulator_active);
		foreach (amts[i]) begin
			wr(fnd_pkg::FRAC_CFG_ADDR, {1'b0, 2'(i), 5'h10});
			span(1, 1, p);
			chk("dither amount", amts[i], dither_level);
		end
		chk("range bit clear", 0, vco_range_high);
		@(posedge ref_clk);
		resetn <= 1'b0;
		#1;
		chk("active in reset", 0, modulator_active);
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(fnd_pkg::FRAC_CFG_ADDR, d);
		chk("fraction after reset", 0, d);
		results();
	end
endmodule
